// [hdl/csc_ctrl.sv]
// Clock source selection, start-up timing and trim register with APB access.
//
// What this block does
// - Decode four-bit clock source fuse field
// - Fuse bit one unprogrammed, zero programmed
// - Count source clock start-up cycles on wake, except from converter sleep
// - Add 4K or 64K watchdog cycles from reset
// - Shipped fuses give RC, longest delay, divide-eight
// - Copy factory calibration into trim once the synchronisers settle after reset
// - Software may overwrite trim; RC follows it
// - Reset delay always timed by watchdog oscillator
// - RC: 6 cycle wake, SUT sets reset delay
// - Crystal range from clock select bits three-one
// - Crystal wake count from select bit zero, SUT
// - Async timer clock keeps running in sleep, except power-down
// - Converter clock runs while CPU halted in converter sleep only
// - Program memory clock gated with CPU clock
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module csc_ctrl
  import csc_pkg::*;
#(
  parameter int WDT_LONG_CYC = 65536,
  parameter int XTAL_LONG_CK = 16384,
  parameter int LF_LONG_CK = 32768
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csc_pkg::csc_fuse_t fuse_pins,
  input wire logic [7:0] factory_cal,
  input wire logic wdt_osc_in,
  input wire logic src_clk_in,
  input wire logic wake_in,
  output csc_pkg::csc_osc_cfg_t osc_cfg,
  output csc_pkg::csc_clk_en_t clk_en,
  output logic core_run
);

  // ==========================================================
  // Elaboration checks
  generate
    if (WDT_LONG_CYC < 1 || WDT_LONG_CYC >= (1 << CNT_W)) begin : g_bad_wdt
      $error("WDT_LONG_CYC does not fit the start-up counter.");
    end
    if (XTAL_LONG_CK < 1 || XTAL_LONG_CK + CK_RESET >= (1 << CNT_W)) begin : g_bad_xtal
      $error("XTAL_LONG_CK does not fit the start-up counter.");
    end
    if (LF_LONG_CK < 1 || LF_LONG_CK + CK_RESET >= (1 << CNT_W)) begin : g_bad_lf
      $error("LF_LONG_CK does not fit the start-up counter.");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_SETTLE, ST_WDT_DELAY, ST_SRC_START, ST_RUN, ST_SLEEP, ST_WAKE, ST_HOLD
  } csc_state_t;

  localparam int SYNC_W = 18;

  csc_state_t state;
  csc_fuse_t fuses;
  logic [CNT_W-1:0] cnt;
  logic [7:0] trim;
  logic [1:0] sleep_mode;
  logic [SYNC_W-1:0] sync_level;
  logic [SYNC_W-1:0] sync_rise;
  csc_fuse_t fuse_sync;
  logic [7:0] cal_sync;
  logic wdt_tick;
  logic src_tick;
  logic wake_rise;
  logic settle_done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic sleep_go;
  csc_src_t src;
  logic rsvd;
  logic [31:0] rd_mux;

  // ==========================================================
  // Input synchronisers
  csc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({fuse_pins, factory_cal, wdt_osc_in, src_clk_in, wake_in}),
    .level(sync_level),
    .rise(sync_rise)
  );

  assign fuse_sync = sync_level[17:11];
  assign cal_sync = sync_level[10:3];
  assign wdt_tick = sync_rise[2];
  assign src_tick = sync_rise[1];
  assign wake_rise = sync_rise[0];

  // ==========================================================
  // Fuse decoding functions
  function automatic csc_src_t decode_src(input logic [3:0] c);
    csc_src_t s;
    s = SRC_RSVD;
    if (c[3]) begin
      s = SRC_XTAL;
    end else if (c[2:1] == 2'h3) begin
      s = SRC_LF_XTAL;
    end else if (c == 4'h2) begin
      s = SRC_RC;
    end else if (c == 4'h0) begin
      s = SRC_EXT;
    end
    return s;
  endfunction

  // Reserved clock select codes and, outside crystal mode, start-up code 11.
  function automatic logic is_reserved(input csc_fuse_t f);
    return decode_src(f.clock_source_select_fuses) == SRC_RSVD ||
           (!f.clock_source_select_fuses[3] && f.startup_time_fuses == 2'h3);
  endfunction

  // Source clock cycles needed before execution after a wake.
  function automatic logic [CNT_W-1:0] wake_ck(input csc_fuse_t f);
    logic [2:0] idx;
    logic [CNT_W-1:0] n;
    idx = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    n = CNT_W'(CK_WAKE_SHORT);
    unique case (decode_src(f.clock_source_select_fuses))
      SRC_XTAL: begin
        if (idx <= 3'h1) begin
          n = CNT_W'(CK_258);
        end else if (idx <= 3'h4) begin
          n = CNT_W'(CK_1K);
        end else begin
          n = CNT_W'(XTAL_LONG_CK);
        end
      end
      SRC_LF_XTAL: begin
        n = f.clock_source_select_fuses[0] ? CNT_W'(LF_LONG_CK) : CNT_W'(CK_1K);
      end
      SRC_RC, SRC_EXT, SRC_RSVD: begin
        n = CNT_W'(CK_WAKE_SHORT);
      end
    endcase
    return n;
  endfunction

  // Watchdog oscillator cycles added after reset; zero means none.
  function automatic logic [CNT_W-1:0] reset_wdt(input csc_fuse_t f);
    logic [1:0] sel;
    logic [2:0] idx;
    idx = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    sel = f.startup_time_fuses;
    if (f.clock_source_select_fuses[3]) begin
      sel = (idx == 3'h2 || idx == 3'h5) ? 2'h0 :
            (idx == 3'h1 || idx == 3'h4 || idx == 3'h7) ? 2'h2 : 2'h1;
    end
    unique case (sel)
      2'h1: return CNT_W'(WDT_SHORT_CYC);
      2'h2: return CNT_W'(WDT_LONG_CYC);
      default: return '0;
    endcase
  endfunction

  assign src = decode_src(fuses.clock_source_select_fuses);
  assign rsvd = is_reserved(fuses);
  assign settle_done = (state == ST_SETTLE) && (cnt == CNT_W'(SETTLE_CYC));

  // ==========================================================
  // APB decode
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = paddr == CSC_CTRL_OFS || paddr == CSC_TRIM_OFS ||
                   paddr == CSC_STATUS_OFS || paddr == CSC_COUNT_OFS;
  assign pslverr = psel && penable && !addr_ok;
  assign sleep_go = wr_en && paddr == CSC_CTRL_OFS && pwdata[CTRL_GO_BIT];

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      CSC_CTRL_OFS: begin
        rd_mux[CTRL_MODE_LSB +: 2] = sleep_mode;
      end
      CSC_TRIM_OFS: begin
        rd_mux[7:0] = trim;
      end
      CSC_STATUS_OFS: begin
        rd_mux[STAT_CKSEL_LSB +: 4] = fuses.clock_source_select_fuses;
        rd_mux[STAT_SUT_LSB +: 2] = fuses.startup_time_fuses;
        rd_mux[STAT_DIV8_BIT] = fuses.divide_by_eight_fuse;
        rd_mux[STAT_SRC_LSB +: 3] = src;
        rd_mux[STAT_RSVD_BIT] = rsvd;
        rd_mux[STAT_RUN_BIT] = core_run;
        rd_mux[STAT_SLEEP_BIT] = state == ST_SLEEP;
        rd_mux[STAT_RANGE_LSB +: 3] = osc_cfg.oscillator_range_fuses;
      end
      CSC_COUNT_OFS: begin
        rd_mux[CNT_W-1:0] = cnt;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data is captured in the setup phase and shown in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // Sleep mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_mode <= MODE_RESET;
    end else if (wr_en && paddr == CSC_CTRL_OFS && state != ST_SLEEP) begin
      sleep_mode <= pwdata[CTRL_MODE_LSB +: 2];
    end
  end

  // ==========================================================
  // Fuse capture once the synchronisers have settled after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuses <= '1;
    end else if (settle_done) begin
      fuses <= fuse_sync;
    end
  end

  // ==========================================================
  // Trim register: zero at reset, factory value once settled, software may refine it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim <= TRIM_RESET;
    end else if (settle_done) begin
      trim <= cal_sync;
    end else if (wr_en && paddr == CSC_TRIM_OFS && state != ST_SETTLE) begin
      trim <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Start-up sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SETTLE;
      cnt <= '0;
    end else begin
      unique case (state)
        ST_SETTLE: begin
          if (!settle_done) begin
            cnt <= cnt + CNT_W'(1);
          end else if (is_reserved(fuse_sync)) begin
            state <= ST_HOLD;
            cnt <= '0;
          end else if (reset_wdt(fuse_sync) != '0) begin
            state <= ST_WDT_DELAY;
            cnt <= reset_wdt(fuse_sync);
          end else begin
            state <= ST_SRC_START;
            cnt <= wake_ck(fuse_sync) + CNT_W'(CK_RESET);
          end
        end
        ST_WDT_DELAY: begin
          // The watchdog oscillator times this part whatever the source.
          if (wdt_tick) begin
            cnt <= cnt - CNT_W'(1);
            if (cnt == CNT_W'(1)) begin
              state <= ST_SRC_START;
              cnt <= wake_ck(fuses) + CNT_W'(CK_RESET);
            end
          end
        end
        ST_SRC_START, ST_WAKE: begin
          if (src_tick) begin
            cnt <= cnt - CNT_W'(1);
            if (cnt == CNT_W'(1)) begin
              state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (sleep_go) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // The oscillator keeps running in converter sleep, so no restart.
          if (wake_rise) begin
            if (sleep_mode == SLEEP_CONVERTER) begin
              state <= ST_RUN;
            end else begin
              state <= ST_WAKE;
              cnt <= wake_ck(fuses);
            end
          end
        end
        ST_HOLD: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_run <= 1'b0;
      clk_en <= '0;
      osc_cfg <= '0;
    end else begin
      core_run <= state == ST_RUN;
      clk_en.cpu <= state == ST_RUN;
      clk_en.program_memory_clock <= state == ST_RUN;
      clk_en.io <= state == ST_RUN;
      clk_en.converter_clock <= state == ST_RUN ||
        (state == ST_SLEEP && sleep_mode == SLEEP_CONVERTER);
      clk_en.async_timer_clock <= state != ST_SETTLE && state != ST_HOLD &&
        !(state == ST_SLEEP && sleep_mode == SLEEP_POWER_DOWN);
      osc_cfg.source <= src;
      osc_cfg.oscillator_range_fuses <= (src == SRC_XTAL) ?
        fuses.clock_source_select_fuses[3:1] : 3'h0;
      osc_cfg.osc_enable <= state != ST_SETTLE && state != ST_HOLD &&
        !(state == ST_SLEEP && sleep_mode != SLEEP_CONVERTER);
      // A programmed fuse reads zero; shipped parts start divided by eight.
      osc_cfg.div8 <= !fuses.divide_by_eight_fuse;
      osc_cfg.oscillator_trim_register <= trim;
    end
  end

endmodule

// [hdl/csc_sync.sv]
// Three-stage synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module csc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  // ==========================================================
  // Stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change is accepted only once the second and third stages agree.
  always_comb begin
    next_level = (s2 & s3) | (level & (s2 | s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
      rise <= '0;
    end else begin
      level <= next_level;
      rise <= next_level & ~level;
    end
  end

endmodule

// [pkg/csc_pkg.sv]
// Package for the clock source and start-up controller: map, fields, counts and types.
package csc_pkg;

  // ==========================================================
  // Register map (byte addresses on APB)
  localparam logic [11:0] CSC_CTRL_OFS = 12'h000;
  localparam logic [11:0] CSC_TRIM_OFS = 12'h004;
  localparam logic [11:0] CSC_STATUS_OFS = 12'h008;
  localparam logic [11:0] CSC_COUNT_OFS = 12'h00c;

  // ==========================================================
  // Field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int STAT_CKSEL_LSB = 0;
  localparam int STAT_SUT_LSB = 4;
  localparam int STAT_DIV8_BIT = 6;
  localparam int STAT_SRC_LSB = 7;
  localparam int STAT_RSVD_BIT = 10;
  localparam int STAT_RUN_BIT = 11;
  localparam int STAT_SLEEP_BIT = 12;
  localparam int STAT_RANGE_LSB = 13;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int CNT_W = 17;
  localparam int SETTLE_CYC = 4;
  localparam int CK_RESET = 14;
  localparam int CK_WAKE_SHORT = 6;
  localparam int CK_258 = 258;
  localparam int CK_1K = 1024;
  localparam int WDT_SHORT_CYC = 4096;

  // Sleep modes selected in the control register.
  localparam logic [1:0] SLEEP_POWER_DOWN = 2'h0;
  localparam logic [1:0] SLEEP_POWER_SAVE = 2'h1;
  localparam logic [1:0] SLEEP_CONVERTER = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {SRC_XTAL, SRC_LF_XTAL, SRC_RC, SRC_EXT, SRC_RSVD} csc_src_t;

  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic divide_by_eight_fuse;
  } csc_fuse_t;

  typedef struct packed {
    csc_src_t source;
    logic [2:0] oscillator_range_fuses;
    logic osc_enable;
    logic div8;
    logic [7:0] oscillator_trim_register;
  } csc_osc_cfg_t;

  typedef struct packed {
    logic cpu;
    logic program_memory_clock;
    logic io;
    logic converter_clock;
    logic async_timer_clock;
  } csc_clk_en_t;

endpackage

// [verif/csc_chk_properties.sv]
// Checker of port relations for the clock source and start-up controller.
`timescale 1ns/1ps
module csc_chk
  import csc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire csc_pkg::csc_fuse_t fuse_pins,
  input wire logic [7:0] factory_cal,
  input wire logic src_clk_in,
  input wire csc_pkg::csc_osc_cfg_t osc_cfg,
  input wire csc_pkg::csc_clk_en_t clk_en,
  input wire logic core_run
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [3:0] cs;
  logic [7:0] wr_trim;
  logic wr;
  logic src_d;
  logic [7:0] src_rises;
  // Source pin rises since reset, saturating; the core may not run before enough of them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d <= 1'b0;
      src_rises <= 8'h00;
    end else begin
      src_d <= src_clk_in;
      if (src_clk_in && !src_d && src_rises != 8'hff) begin
        src_rises <= src_rises + 8'h01;
      end
    end
  end
  assign cs = fuse_pins.clock_source_select_fuses;
  assign wr = psel && penable && pwrite && paddr == CSC_TRIM_OFS && core_run;
  always_ff @(posedge pclk) begin
    if (wr) begin
      wr_trim <= pwdata[7:0];
    end
  end
  src_decode_a: assert property (core_run |-> osc_cfg.source == (
    cs[3] ? SRC_XTAL : cs[3:1] == 3'h3 ? SRC_LF_XTAL : cs == 4'h2 ? SRC_RC : SRC_EXT))
    else $error("source decode wrong");
  rsvd_hold_a: assert property (
    cs == 4'h3 || cs == 4'h1 || cs[3:1] == 3'h2 |-> !core_run)
    else $error("reserved code released the core");
  div8_fuse_a: assert property (
    core_run |-> osc_cfg.div8 == !fuse_pins.divide_by_eight_fuse)
    else $error("divide-by-eight polarity wrong");
  range_sel_a: assert property (
    core_run && osc_cfg.source == SRC_XTAL |-> osc_cfg.oscillator_range_fuses == cs[3:1])
    else $error("oscillator range wrong");
  trim_load_a: assert property (
    $rose(core_run) |-> osc_cfg.oscillator_trim_register == factory_cal)
    else $error("factory trim not loaded");
  trim_write_a: assert property (
    wr |-> ##[1:2] osc_cfg.oscillator_trim_register == wr_trim)
    else $error("trim write not applied");
  flash_gate_a: assert property (
    clk_en.program_memory_clock == clk_en.cpu)
    else $error("program memory clock apart from cpu clock");
  domains_a: assert property (
    clk_en.cpu |-> clk_en.converter_clock && clk_en.async_timer_clock)
    else $error("timer or converter domain off while running");
  release_a: assert property (
    $rose(core_run) |-> clk_en.cpu && src_rises >= 8'h14)
    else $error("core released with cpu clock off");
endmodule

bind csc_ctrl csc_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .fuse_pins, .factory_cal, .src_clk_in, .osc_cfg, .clk_en, .core_run);

// [verif/csc_osc_model.sv]
// Behavioural resonator and watchdog oscillator facing the controller.
`timescale 1ns/1ps
module csc_osc_model #(
  parameter int HALF = 3,
  parameter int SRC_HALF = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic wdt_osc,
  output logic src_clk
);
  int cnt;
  int src_cnt;
  // The watchdog oscillator runs on its own, whatever source is chosen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      wdt_osc <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      wdt_osc <= ~wdt_osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // The resonator runs at its own rate, so a delay timed from the wrong pin shows up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_cnt <= 0;
      src_clk <= 1'b0;
    end else if (src_cnt == SRC_HALF - 1) begin
      src_cnt <= 0;
      src_clk <= ~src_clk;
    end else begin
      src_cnt <= src_cnt + 1;
    end
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the clock source and start-up controller.
`timescale 1ns/1ps
module testbench;
  import csc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wake_in, pready, pslverr, core_run, e;
  logic wdt_osc, src_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] cal;
  logic [3:0] rsv [4];
  csc_fuse_t fuse;
  csc_osc_cfg_t cfg;
  csc_clk_en_t ce;
  int err_total, tests_run, n;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  csc_osc_model #(.HALF(3), .SRC_HALF(4)) osc_u (.pclk(pclk), .presetn(presetn),
    .wdt_osc(wdt_osc),
    .src_clk(src_clk));
  csc_ctrl #(.WDT_LONG_CYC(64), .XTAL_LONG_CK(32), .LF_LONG_CK(32)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_pins(fuse), .factory_cal(cal), .wdt_osc_in(wdt_osc), .src_clk_in(src_clk),
    .wake_in(wake_in), .osc_cfg(cfg), .clk_en(ce), .core_run(core_run));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    tests_run++;
    if (g !== x) fail(m);
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi, input string m);
    tests_run++;
    if (g < lo || g > hi) fail(m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fail("bus timeout");
      tally_and_finish();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts falling edges until the chosen output reaches the level.
  task automatic wait_for(input int sel, input logic lvl, input int bnd, input logic must);
    n = 0;
    while (n < bnd && (sel ? ce.cpu : core_run) !== lvl) begin
      @(negedge pclk);
      n++;
    end
    if (must && n == bnd) begin
      fail("wait timeout");
      tally_and_finish();
    end
  endtask
  task automatic do_reset(input logic [6:0] f);
    @(posedge pclk);
    presetn <= 1'b0;
    fuse <= f;
    cal <= cal + 8'h35;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic boot(input logic [6:0] f, input int wdt, input int sc, input logic [2:0] s,
                      input logic [2:0] r);
    int x;
    do_reset(f);
    x = wdt * 6 + sc * 8;
    wait_for(0, 1'b1, x + 200, 1'b1);
    chk_rng(n, x - 2, x + 30, "start-up length");
    chk({29'h0, cfg.source}, {29'h0, s}, "source");
    apb(1'b0, CSC_STATUS_OFS, 32'h0);
    chk(rd, {16'h0, r, 3'b010, s, f[0], f[2:1], f[6:3]}, "status");
    chk({31'h0, cfg.div8}, {31'h0, ~f[0]}, "div8");
    apb(1'b0, CSC_TRIM_OFS, 32'h0);
    chk(rd, {24'h0, cal}, "trim load");
    $display("boot %b end", f);
  endtask
  task automatic sleep(input logic [1:0] m, input int lo, input int hi);
    apb(1'b1, CSC_CTRL_OFS, {29'h0, m, 1'b1});
    wait_for(1, 1'b0, 50, 1'b1);
    chk({27'h0, ce}, {30'h0, m == 2'h2, m != 2'h0}, "sleep enables");
    chk({31'h0, cfg.osc_enable}, {31'h0, m == 2'h2}, "osc gate");
    @(posedge pclk);
    wake_in <= 1'b1;
    wait_for(1, 1'b1, 400, 1'b1);
    chk_rng(n, lo, hi, "wake length");
    @(posedge pclk);
    wake_in <= 1'b0;
    apb(1'b0, CSC_CTRL_OFS, 32'h0);
    chk(rd, {29'h0, m, 1'b0}, "mode read");
    $display("sleep %0d end", m);
  endtask
  task automatic hold(input logic [6:0] f);
    do_reset(f);
    wait_for(0, 1'b1, 1500, 1'b0);
    chk_rng(n, 1500, 1500, "reserved hold");
    apb(1'b0, CSC_STATUS_OFS, 32'h0);
    $display("hold %b end", f);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    wake_in = 1'b0;
    cal = 8'h9c;
    fuse = 7'h7f;
    err_total = 0;
    tests_run = 0;
    rsv = '{4'h3, 4'h1, 4'h5, 4'h4};
    boot(7'b0010_10_0, 64, 20, SRC_RC, 3'h0);
    boot(7'b0010_01_1, 4096, 20, SRC_RC, 3'h0);
    boot(7'b0010_00_1, 0, 20, SRC_RC, 3'h0);
    sleep(SLEEP_POWER_DOWN, 28, 70);
    sleep(SLEEP_POWER_SAVE, 28, 70);
    sleep(SLEEP_CONVERTER, 0, 15);
    apb(1'b1, CSC_TRIM_OFS, 32'hffff_ff5a);
    apb(1'b0, CSC_TRIM_OFS, 32'h0);
    chk(rd, 32'h5a, "trim read");
    chk({24'h0, cfg.oscillator_trim_register}, 32'h5a, "trim out");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("trim and bus end");
    boot(7'b1110_01_1, 64, 272, SRC_XTAL, 3'h7);
    boot(7'b1001_01_1, 0, 46, SRC_XTAL, 3'h4);
    boot(7'b1100_10_1, 0, 1038, SRC_XTAL, 3'h6);
    boot(7'b1011_00_1, 64, 1038, SRC_XTAL, 3'h5);
    boot(7'b0110_00_1, 0, 1038, SRC_LF_XTAL, 3'h0);
    boot(7'b0111_00_1, 0, 46, SRC_LF_XTAL, 3'h0);
    boot(7'b0000_10_1, 64, 20, SRC_EXT, 3'h0);
    foreach (rsv[i]) begin
      hold({rsv[i], 3'b001});
      chk({31'h0, rd[STAT_RSVD_BIT]}, 32'h1, "reserved flag");
    end
    hold(7'b0010_11_1);
    tally_and_finish();
  end
endmodule
